// [dad_map.svh]
// register offsets, field positions and reset values of the adjust/decrement unit
`ifndef DAD_MAP_SVH
`define DAD_MAP_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define DAD_OFS_ACC        4'h0
`define DAD_OFS_STATUS     4'h1
`define DAD_OFS_CTRL       4'h2
`define DAD_OFS_BANK       4'h3
`define DAD_OFS_INDEX_LO   4'h4
`define DAD_OFS_INDEX_HI   4'h5
`define DAD_OFS_MPTR_LO    4'h6
`define DAD_OFS_MPTR_HI    4'h7
`define DAD_OFS_MDATA      4'h8
`define DAD_OFS_LAST_ADDR  4'h9

// ***************************************************************
// field positions
// ***************************************************************
`define DAD_STATUS_CARRY   0
`define DAD_STATUS_HALF    1
`define DAD_CTRL_EXT_EN    0

// ***************************************************************
// reset values and decode constants
// ***************************************************************
`define DAD_RST_BYTE       8'h00
`define DAD_RST_ADDR       12'h000
`define DAD_BCD_MAX        4'h9
`define DAD_BCD_FIX        4'h6
`define DAD_INDEXED_MAX    8'h5F
`define DAD_ACCESS_HI_BASE 12'hF00

`endif

// [dad_pkg.sv]
// types shared by the adjust/decrement unit
package dad_pkg;
   typedef enum logic [1:0] {
      DAD_OP_NONE,
      DAD_OP_BCD,
      DAD_OP_DEC
   } dad_op_t;

   typedef logic [7:0]  dad_byte_t;
   typedef logic [11:0] dad_addr_t;
endpackage

// [dad_alu_if.sv]
// operands and results between the unit and its arithmetic core
interface dad_alu_if;
   logic [7:0] acc;
   logic       carry;
   logic       half_carry;
   logic [7:0] mem_byte;
   logic [7:0] bcd_result;
   logic       bcd_carry;
   logic [7:0] dec_result;
   logic       dec_carry;

   modport core (
      input  acc, carry, half_carry, mem_byte,
      output bcd_result, bcd_carry, dec_result, dec_carry
   );
   modport user (
      output acc, carry, half_carry, mem_byte,
      input  bcd_result, bcd_carry, dec_result, dec_carry
   );
endinterface

// [dad_alu.sv]
// combinational core: packed-bcd correction and byte decrement
`include "dad_map.svh"

module dad_alu (
   dad_alu_if.core alu
);
   import dad_pkg::*;

   logic [8:0] lo_fixed;
   logic [8:0] hi_fixed;
   logic       lo_need;
   logic       hi_need;

   always_comb begin
      lo_need  = (alu.acc[3:0] > `DAD_BCD_MAX) || alu.half_carry;
      lo_fixed = {1'b0, alu.acc} + (lo_need ? 9'h006 : 9'h000);
      // the low fix may carry into the upper digit, so test after it
      hi_need  = (lo_fixed[7:4] > `DAD_BCD_MAX) || alu.carry
                 || lo_fixed[8];
      hi_fixed = lo_fixed + (hi_need ? 9'h060 : 9'h000);
   end

   assign alu.bcd_result = hi_fixed[7:0];
   assign alu.bcd_carry  = hi_need;
   assign alu.dec_result = alu.mem_byte - 8'h01;
   // carry reads as "no borrow"
   assign alu.dec_carry  = (alu.mem_byte != 8'h00);
endmodule

// [dad_exec.sv]
// accumulator, flags and data memory executing bcd correct and decrement
`include "dad_map.svh"

module dad_exec #(
   parameter int MEM_AW = 12
) (
   // clock, reset, enable
   input  wire logic                  clk_in,
   input  wire logic                  reset_n_in,
   input  wire logic                  ce_in,
   // instruction issue
   input  wire logic                  op_valid_in,
   input  wire dad_pkg::dad_op_t      op_kind_in,
   input  wire logic [7:0]            op_file_in,
   input  wire logic                  op_dest_in,
   input  wire logic                  op_access_in,
   // register port
   input  wire logic [3:0]            reg_addr_in,
   input  wire logic [7:0]            reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   output logic      [7:0]            reg_rdata_out,
   // execution results
   output logic                       done_out,
   output logic      [7:0]            result_out,
   output logic                       carry_out
);
   import dad_pkg::*;

   dad_alu_if alu ();

   dad_byte_t mem_q [0:(1<<MEM_AW)-1];
   dad_byte_t acc_q;
   logic      carry_q;
   logic      half_carry_q;
   logic      ext_en_q;
   logic [3:0] bank_pointer_q;
   dad_addr_t index_q;
   dad_addr_t mptr_q;
   dad_addr_t last_addr_q;
   dad_byte_t rdata_q;
   logic      done_q;
   dad_byte_t result_q;

   dad_addr_t eff_addr;
   logic      run_bcd;
   logic      run_dec;
   logic      dec_to_mem;
   logic      bus_mem_wr;

   // ***************************************************************
   // operand addressing
   // ***************************************************************
   always_comb begin
      if (!op_access_in && ext_en_q
          && (op_file_in <= `DAD_INDEXED_MAX)) begin
         eff_addr = index_q + {4'h0, op_file_in};
      end else if (op_access_in) begin
         eff_addr = {bank_pointer_q, op_file_in};
      end else if (op_file_in <= `DAD_INDEXED_MAX) begin
         eff_addr = {4'h0, op_file_in};
      end else begin
         eff_addr = `DAD_ACCESS_HI_BASE | {4'h0, op_file_in};
      end
   end

   assign run_bcd    = ce_in && op_valid_in && (op_kind_in == DAD_OP_BCD);
   assign run_dec    = ce_in && op_valid_in && (op_kind_in == DAD_OP_DEC);
   assign dec_to_mem = run_dec && op_dest_in;
   assign bus_mem_wr = ce_in && reg_wr_in
                       && (reg_addr_in == `DAD_OFS_MDATA);

   assign alu.acc        = acc_q;
   assign alu.carry      = carry_q;
   assign alu.half_carry = half_carry_q;
   assign alu.mem_byte   = mem_q[eff_addr[MEM_AW-1:0]];

   dad_alu u_alu (
      .alu (alu.core)
   );

   // ***************************************************************
   // data memory
   // ***************************************************************
   // instruction write-back wins over a bus write in the same cycle
   always_ff @(posedge clk_in) begin
      if (dec_to_mem) begin
         mem_q[eff_addr[MEM_AW-1:0]] <= alu.dec_result;
      end else if (bus_mem_wr) begin
         mem_q[mptr_q[MEM_AW-1:0]] <= reg_wdata_in;
      end
   end

   // ***************************************************************
   // accumulator and flags
   // ***************************************************************
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         acc_q <= `DAD_RST_BYTE;
      end else if (ce_in) begin
         if (run_bcd) begin
            acc_q <= alu.bcd_result;
         end else if (run_dec && !op_dest_in) begin
            acc_q <= alu.dec_result;
         end else if (reg_wr_in && reg_addr_in == `DAD_OFS_ACC) begin
            acc_q <= reg_wdata_in;
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         carry_q      <= 1'b0;
         half_carry_q <= 1'b0;
      end else if (ce_in) begin
         if (run_bcd) begin
            carry_q <= alu.bcd_carry;
         end else if (run_dec) begin
            carry_q <= alu.dec_carry;
         end else if (reg_wr_in && reg_addr_in == `DAD_OFS_STATUS) begin
            carry_q      <= reg_wdata_in[`DAD_STATUS_CARRY];
            half_carry_q <= reg_wdata_in[`DAD_STATUS_HALF];
         end
      end
   end

   // ***************************************************************
   // software-held configuration
   // ***************************************************************
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ext_en_q       <= 1'b0;
         bank_pointer_q <= 4'h0;
         index_q        <= `DAD_RST_ADDR;
         mptr_q         <= `DAD_RST_ADDR;
      end else if (ce_in && reg_wr_in) begin
         case (reg_addr_in)
            `DAD_OFS_CTRL: begin
               ext_en_q <= reg_wdata_in[`DAD_CTRL_EXT_EN];
            end
            `DAD_OFS_BANK: begin
               bank_pointer_q <= reg_wdata_in[3:0];
            end
            `DAD_OFS_INDEX_LO: begin
               index_q[7:0] <= reg_wdata_in;
            end
            `DAD_OFS_INDEX_HI: begin
               index_q[11:8] <= reg_wdata_in[3:0];
            end
            `DAD_OFS_MPTR_LO: begin
               mptr_q[7:0] <= reg_wdata_in;
            end
            `DAD_OFS_MPTR_HI: begin
               mptr_q[11:8] <= reg_wdata_in[3:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ***************************************************************
   // execution results
   // ***************************************************************
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         done_q      <= 1'b0;
         result_q    <= `DAD_RST_BYTE;
         last_addr_q <= `DAD_RST_ADDR;
      end else if (ce_in) begin
         done_q <= run_bcd || run_dec;
         if (run_bcd) begin
            result_q <= alu.bcd_result;
         end else if (run_dec) begin
            result_q    <= alu.dec_result;
            last_addr_q <= eff_addr;
         end
      end
   end

   // ***************************************************************
   // register read port
   // ***************************************************************
   // read data stand for one cycle after the strobe, or longer while ce_in is held low
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_q <= `DAD_RST_BYTE;
      end else if (ce_in) begin
         rdata_q <= `DAD_RST_BYTE;
         if (reg_rd_in) begin
            case (reg_addr_in)
               `DAD_OFS_ACC:       rdata_q <= acc_q;
               `DAD_OFS_STATUS:    rdata_q <= {6'h00, half_carry_q, carry_q};
               `DAD_OFS_CTRL:      rdata_q <= {7'h00, ext_en_q};
               `DAD_OFS_BANK:      rdata_q <= {4'h0, bank_pointer_q};
               `DAD_OFS_INDEX_LO:  rdata_q <= index_q[7:0];
               `DAD_OFS_INDEX_HI:  rdata_q <= {4'h0, index_q[11:8]};
               `DAD_OFS_MPTR_LO:   rdata_q <= mptr_q[7:0];
               `DAD_OFS_MPTR_HI:   rdata_q <= {4'h0, mptr_q[11:8]};
               `DAD_OFS_MDATA:     rdata_q <= mem_q[mptr_q[MEM_AW-1:0]];
               `DAD_OFS_LAST_ADDR: rdata_q <= last_addr_q[7:0];
               default:            rdata_q <= `DAD_RST_BYTE;
            endcase
         end
      end
   end

   assign reg_rdata_out = rdata_q;
   assign done_out      = done_q;
   assign result_out    = result_q;
   assign carry_out     = carry_q;
endmodule

// [dad_exec_sva.sv]
// port assertions of the adjust/decrement unit
module dad_exec_sva
   import dad_pkg::*;
#(
   parameter int MEM_AW = 12
) (
   // clock, reset, enable
   input wire logic            clk_in,
   input wire logic            reset_n_in,
   input wire logic            ce_in,
   // instruction issue
   input wire logic            op_valid_in,
   input wire dad_pkg::dad_op_t op_kind_in,
   input wire logic [7:0]      op_file_in,
   input wire logic            op_dest_in,
   input wire logic            op_access_in,
   // register port
   input wire logic [3:0]      reg_addr_in,
   input wire logic [7:0]      reg_wdata_in,
   input wire logic            reg_wr_in,
   input wire logic            reg_rd_in,
   input wire logic [7:0]      reg_rdata_out,
   // results
   input wire logic            done_out,
   input wire logic [7:0]      result_out,
   input wire logic            carry_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   wire logic bcd_go = ce_in && op_valid_in && op_kind_in == DAD_OP_BCD;
   wire logic dec_go = ce_in && op_valid_in && op_kind_in == DAD_OP_DEC;
   wire logic [3:0] lo_w = reg_wdata_in[3:0];
   // ****************************************************
   // sequences
   // ****************************************************
   sequence acc_load;
      ce_in && reg_wr_in && !op_valid_in && reg_addr_in == 4'h0
      && lo_w > 4'h9
      ##1 bcd_go && !reg_wr_in;
   endsequence
   // the read must not share its cycle with an op, or acc moves again
   sequence dec_acc;
      dec_go && !op_dest_in
      ##1 ce_in && !op_valid_in && !reg_wr_in && reg_rd_in
      && reg_addr_in == 4'h0;
   endsequence
   chk_low_fix: assert property (
      acc_load |=> result_out[3:0] == $past(lo_w, 2) + 4'h6)
      else $error("low digit not corrected");
   chk_high_fix: assert property (
      bcd_go |=> carry_out || result_out[7:4] <= 4'h9)
      else $error("high digit left above nine");
   chk_carry_keep: assert property (
      bcd_go && carry_out |=> carry_out)
      else $error("carry lost by correction");
   chk_acc_dest: assert property (
      dec_acc |=> reg_rdata_out == $past(result_out))
      else $error("decrement not in accumulator");
   chk_dec_carry: assert property (
      dec_go |=> carry_out == (result_out != 8'hFF))
      else $error("decrement carry wrong");
   chk_done_pulse: assert property (
      bcd_go || dec_go |=> done_out)
      else $error("done missing after op");
endmodule

bind dad_exec dad_exec_sva #(.MEM_AW(MEM_AW)) i_dad_exec_sva (
   .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
   .op_valid_in(op_valid_in), .op_kind_in(op_kind_in),
   .op_file_in(op_file_in), .op_dest_in(op_dest_in),
   .op_access_in(op_access_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .done_out(done_out), .result_out(result_out), .carry_out(carry_out)
);

// [dad_exec_tb.sv]
// self-checking bench of the adjust/decrement unit
module dad_exec_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import dad_pkg::*;
   logic       clk_in = 1'b0;
   logic       reset_n_in = 1'b0;
   logic       ce_in = 1'b1;
   logic       op_valid_in = 1'b0;
   logic       op_dest_in = 1'b0;
   logic       op_access_in = 1'b0;
   logic       reg_wr_in = 1'b0;
   logic       reg_rd_in = 1'b0;
   dad_op_t    op_kind_in = DAD_OP_NONE;
   logic [7:0] op_file_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic [3:0] reg_addr_in = 4'h0;
   logic [7:0] reg_rdata_out;
   logic [7:0] result_out;
   logic       done_out;
   logic       carry_out;
   int         bad_count = 0;
   int         tests_run = 0;

   dad_exec #(.MEM_AW(12)) i_dad_exec (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
      .op_valid_in(op_valid_in), .op_kind_in(op_kind_in),
      .op_file_in(op_file_in), .op_dest_in(op_dest_in),
      .op_access_in(op_access_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .done_out(done_out), .result_out(result_out), .carry_out(carry_out)
   );

   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   // ****************************************************
   // bus and compare tasks
   // ****************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // wr and op set reg_wr_in and op_valid_in; rd clears both and releases its own reg_rd_in
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_wr_in <= 1'b1;
      op_valid_in <= 1'b0;
      reg_addr_in <= a;
      reg_wdata_in <= d;
   endtask
   task automatic op(input dad_op_t k, input logic [7:0] f,
                     input logic d, input logic a);
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      op_valid_in <= 1'b1;
      op_kind_in <= k;
      op_file_in <= f;
      op_dest_in <= d;
      op_access_in <= a;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      op_valid_in <= 1'b0;
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 chk(reg_rdata_out, exp);
   endtask
   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic t_bcd();
      logic [7:0] acc[6] = '{8'hA5, 8'hCE, 8'h12, 8'h12, 8'h99, 8'h9A};
      logic [1:0] st[6] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0};
      logic [7:0] res[6] = '{8'h05, 8'h34, 8'h18, 8'h72, 8'h99, 8'h00};
      logic       cy[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      for (int i = 0; i < 6; i++) begin
         wr(4'h1, {6'h00, st[i]});
         wr(4'h0, acc[i]);
         op(DAD_OP_BCD, 8'h00, 1'b0, 1'b0);
         @(posedge clk_in);
         op_valid_in <= 1'b0;
         #1 chk({7'h00, done_out}, 8'h01);
         chk({7'h00, carry_out}, {7'h00, cy[i]});
         chk(result_out, res[i]);
         rd(4'h0, res[i]);
         rd(4'h1, {6'h00, st[i][1], cy[i]});
         chk(result_out, res[i]);
         chk({7'h00, done_out}, 8'h00);
      end
   endtask
   task automatic t_dec();
      wr(4'h3, 8'h02);
      wr(4'h6, 8'h34);
      wr(4'h7, 8'h02);
      wr(4'h8, 8'h01);
      op(DAD_OP_DEC, 8'h34, 1'b0, 1'b1);
      rd(4'h0, 8'h00);
      chk({7'h00, carry_out}, 8'h01);
      rd(4'h8, 8'h01);
      op(DAD_OP_DEC, 8'h34, 1'b1, 1'b1);
      rd(4'h8, 8'h00);
      op(DAD_OP_DEC, 8'h34, 1'b1, 1'b1);
      rd(4'h8, 8'hFF);
      // decrement of zero borrows, so carry reads low
      chk({7'h00, carry_out}, 8'h00);
      wr(4'hF, 8'h55);
      rd(4'hF, 8'h00);
   endtask
   // index 1A0 plus 5F lands on 1FF; 60 falls out of the indexed range
   task automatic t_index();
      wr(4'h2, 8'h01);
      wr(4'h4, 8'hA0);
      wr(4'h5, 8'h01);
      wr(4'h6, 8'hFF);
      wr(4'h7, 8'h01);
      wr(4'h8, 8'h10);
      op(DAD_OP_DEC, 8'h5F, 1'b1, 1'b0);
      rd(4'h8, 8'h0F);
      rd(4'h9, 8'hFF);
      wr(4'h6, 8'h60);
      wr(4'h7, 8'h0F);
      wr(4'h8, 8'h05);
      op(DAD_OP_DEC, 8'h60, 1'b1, 1'b0);
      rd(4'h8, 8'h04);
      wr(4'h2, 8'h00);
      wr(4'h6, 8'h10);
      wr(4'h7, 8'h00);
      wr(4'h8, 8'h20);
      op(DAD_OP_DEC, 8'h10, 1'b1, 1'b0);
      rd(4'h8, 8'h1F);
   endtask

   // with the enable low neither a bus write nor an op may move state
   task automatic t_hold();
      wr(4'h0, 8'h3C);
      wr(4'h0, 8'h77);
      ce_in <= 1'b0;
      op(DAD_OP_BCD, 8'h00, 1'b0, 1'b0);
      @(posedge clk_in);
      ce_in <= 1'b1;
      op_valid_in <= 1'b0;
      #1 chk({7'h00, done_out}, 8'h00);
      rd(4'h0, 8'h3C);
   endtask

   task automatic give_verdict();
      if (bad_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #100us;
      bad_count++;
      give_verdict();
   end
   initial begin
      repeat (6) @(posedge clk_in);
      reset_n_in <= 1'b1;
      rd(4'h0, 8'h00);
      t_bcd();
      t_dec();
      t_index();
      t_hold();
      give_verdict();
   end
endmodule
